// ---- pndt_pkg.sv ----
// Purpose: shared constants for the pattern next-data transfer block
// Assumes: 16-bit register port, byte-wide registers in low bits
// Notes:   offsets are register addresses on the plain port
package pndt_pkg;
  localparam logic [15:0] OFF_NEXT_HIGH      = 16'hffa4;
  localparam logic [15:0] OFF_NEXT_LOW       = 16'hffa5;
  localparam logic [15:0] OFF_NEXT_GRP2_ALT  = 16'hffa6;
  localparam logic [15:0] OFF_NEXT_GRP0_ALT  = 16'hffa7;
  localparam logic [15:0] OFF_HIGH_EN        = 16'hffa2;
  localparam logic [15:0] OFF_LOW_EN         = 16'hffa3;
  localparam logic [15:0] OFF_TRIG_SEL       = 16'hffa1;
  localparam logic [15:0] OFF_LOW_DIR        = 16'hffd1;
  localparam logic [15:0] OFF_LOW_OUT        = 16'hffd3;
  localparam logic [15:0] OFF_HIGH_DIR       = 16'hffd4;
  localparam logic [15:0] OFF_HIGH_OUT       = 16'hffd6;
  localparam logic [7:0]  RST_BYTE_ZERO      = 8'h00;
  localparam logic [7:0]  RST_TRIG_SEL       = 8'hff;
  localparam logic [7:0]  READ_ONES          = 8'hff;
  localparam int          GRP_UPPER_LSB      = 4;
  localparam int          TRIG_FIELD_W       = 2;
endpackage : pndt_pkg

// ---- pndt_pair_if.sv ----
// Purpose: carries one group pair's transfer signals to the pair unit
// Assumes: single clock domain
// Notes:   upper nibble is the odd group, lower the even group
`timescale 1ns/10ps
`default_nettype none
interface pndt_pair_if;
  logic [7:0] nextData;
  logic [7:0] enableBits;
  logic [1:0] groupFire;
  logic [7:0] cpuWrData;
  logic [7:0] cpuWrMask;
  logic       cpuWrite;
  logic [7:0] outData;
  modport unit (input nextData, enableBits, groupFire, cpuWrData, cpuWrMask, cpuWrite,
                output outData);
  modport ctrl (output nextData, enableBits, groupFire, cpuWrData, cpuWrMask, cpuWrite,
                input outData);
endinterface : pndt_pair_if
`default_nettype wire

// ---- pndt_pair_out.sv ----
// Purpose: one port output data register fed by a pair of 4-bit groups
// Assumes: fire strobes already decoded per group
// Notes:   enabled bits are read-only to the cpu
`timescale 1ns/10ps
`default_nettype none
module pndt_pair_out
  import pndt_pkg::*;
(
  input wire logic  core_clk,
  input wire logic  rst,
  pndt_pair_if.unit pair
);
  logic [7:0] outData_r;
  logic [7:0] outData_nxt;
  logic [7:0] fireMask;
  logic [7:0] cpuMask;

  // per-bit copy mask: group fire and bit enable
  assign fireMask = {{4{pair.groupFire[1]}}, {4{pair.groupFire[0]}}} & pair.enableBits;
  // cpu may touch only bits not enabled for pattern output
  assign cpuMask  = pair.cpuWrite ? (pair.cpuWrMask & ~pair.enableBits) : 8'h00;
  assign outData_nxt = (outData_r & ~(fireMask | cpuMask))
                     | (pair.nextData & fireMask)
                     | (pair.cpuWrData & cpuMask);

  // output data register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outData_r <= RST_BYTE_ZERO;
    end else begin
      outData_r <= outData_nxt;
    end
  end

  assign pair.outData = outData_r;
endmodule : pndt_pair_out
`default_nettype wire

// ---- pndt_transfer.sv ----
// Purpose: buffered next-data transfer of a 16-bit timing pattern output
// Assumes: compare-match strobes are one-cycle pulses on core_clk
// Notes:   hardware standby is a reset-like input
//          the standby pin is filtered, so its clear lands a few cycles late
//          output data registers survive hardware standby, only rst clears them
//          a cpu write to an enabled output bit is dropped
//          a buffer write in a match cycle: the port takes the old buffer
//          a trigger select write remaps buffer addresses from the next cycle
//          direction registers are write-only and read back as ones
//          unmapped reads return ones, unmapped writes are dropped
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module pndt_transfer
  import pndt_pkg::*;
#(
  parameter int NUM_CHANNELS = 4
)
(
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    hwStandby,
  input  wire logic [15:0]             regAddr,
  input  wire logic [7:0]              regWrData,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [7:0]              regRdData,
  input  wire logic [NUM_CHANNELS-1:0] compareMatch,
  output logic      [15:0]             patternOut,
  output logic      [15:0]             patternDirection
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] nextLow_r;
  logic [7:0] nextHigh_r;
  logic [7:0] lowEnable_r;
  logic [7:0] highEnable_r;
  logic [7:0] trigSel_r;
  logic [7:0] lowDir_r;
  logic [7:0] highDir_r;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic       clearAll;

  ////////////////////////////////////////////////////////////////////////////
  // hardware standby pin synchroniser
  // the pin is not timed to core_clk; three stages keep metastability away
  // from the clear, and a level counts only once stages two and three agree
  logic standbyMeta_r;
  logic standbySync_r;
  logic standbyLate_r;
  logic standbyOn_r;
  logic standbyAgree;

  // three-stage capture of the pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standbyMeta_r <= 1'h0;
      standbySync_r <= 1'h0;
      standbyLate_r <= 1'h0;
    end else begin
      standbyMeta_r <= hwStandby;
      standbySync_r <= standbyMeta_r;
      standbyLate_r <= standbySync_r;
    end
  end

  // stages two and three agree: the level is settled
  assign standbyAgree = standbySync_r == standbyLate_r;

  // filtered standby level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standbyOn_r <= 1'h0;
    end else if (standbyAgree) begin
      standbyOn_r <= standbySync_r;
    end
  end

  // hardware standby clears buffers and control registers like reset
  assign clearAll = standbyOn_r;

  ////////////////////////////////////////////////////////////////////////////
  // trigger select and pair sharing
  function automatic logic fireOf(input logic [1:0] sel,
                                  input logic [NUM_CHANNELS-1:0] cm);
    fireOf = cm[sel];
  endfunction : fireOf

  logic       lowShared;
  logic       highShared;
  logic [3:0] groupFire;
  logic [1:0] trigGrp0;
  logic [1:0] trigGrp1;
  logic [1:0] trigGrp2;
  logic [1:0] trigGrp3;

  // per-group trigger fields, odd group in the upper field of each pair
  assign trigGrp0 = trigSel_r[1:0];
  assign trigGrp1 = trigSel_r[3:2];
  assign trigGrp2 = trigSel_r[5:4];
  assign trigGrp3 = trigSel_r[7:6];

  // equal fields mean one shared trigger
  assign lowShared  = trigGrp0 == trigGrp1;
  assign highShared = trigGrp2 == trigGrp3;

  // per-group match strobes
  assign groupFire[0] = fireOf(trigGrp0, compareMatch);
  assign groupFire[1] = fireOf(trigGrp1, compareMatch);
  assign groupFire[2] = fireOf(trigGrp2, compareMatch);
  assign groupFire[3] = fireOf(trigGrp3, compareMatch);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // one address compare, shared by the write decodes; the read path uses its own case
  function automatic logic hitOf(input logic [15:0] addr,
                                 input logic [15:0] off);
    hitOf = addr == off;
  endfunction : hitOf

  logic hitLowEn;
  logic hitHighEn;
  logic hitTrig;
  logic hitLowDir;
  logic hitHighDir;
  logic hitLowOut;
  logic hitHighOut;
  logic hitNextHigh;
  logic hitNextLow;
  logic hitGrp2Alt;
  logic hitGrp0Alt;
  logic [7:0] lowBufMaskA5;
  logic [7:0] lowBufMaskA7;
  logic [7:0] highBufMaskA4;
  logic [7:0] highBufMaskA6;

  assign hitNextHigh = hitOf(regAddr, OFF_NEXT_HIGH);
  assign hitNextLow  = hitOf(regAddr, OFF_NEXT_LOW);
  assign hitGrp2Alt  = hitOf(regAddr, OFF_NEXT_GRP2_ALT);
  assign hitGrp0Alt  = hitOf(regAddr, OFF_NEXT_GRP0_ALT);
  assign hitLowEn    = hitOf(regAddr, OFF_LOW_EN);
  assign hitHighEn   = hitOf(regAddr, OFF_HIGH_EN);
  assign hitTrig     = hitOf(regAddr, OFF_TRIG_SEL);
  assign hitLowDir   = hitOf(regAddr, OFF_LOW_DIR);
  assign hitHighDir  = hitOf(regAddr, OFF_HIGH_DIR);
  assign hitLowOut   = hitOf(regAddr, OFF_LOW_OUT);
  assign hitHighOut  = hitOf(regAddr, OFF_HIGH_OUT);

  // which buffer bits each address reaches
  assign lowBufMaskA5  = lowShared  ? 8'hff : 8'hf0;
  assign lowBufMaskA7  = lowShared  ? 8'h00 : 8'h0f;
  assign highBufMaskA4 = highShared ? 8'hff : 8'hf0;
  assign highBufMaskA6 = highShared ? 8'h00 : 8'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // next-data buffers
  // keep old bits outside the mask, take write data inside it
  function automatic logic [7:0] mergeBits(input logic [7:0] oldBits,
                                           input logic [7:0] newBits,
                                           input logic [7:0] mask);
    mergeBits = (oldBits & ~mask) | (newBits & mask);
  endfunction : mergeBits

  logic [7:0] lowWrMask;
  logic [7:0] highWrMask;
  logic [7:0] lowWrA5;
  logic [7:0] lowWrA7;
  logic [7:0] highWrA4;
  logic [7:0] highWrA6;

  // writable bits per address; reserved nibbles never reach a buffer
  assign lowWrA5    = (regWrite && hitNextLow)  ? lowBufMaskA5  : 8'h00;
  assign lowWrA7    = (regWrite && hitGrp0Alt)  ? lowBufMaskA7  : 8'h00;
  assign highWrA4   = (regWrite && hitNextHigh) ? highBufMaskA4 : 8'h00;
  assign highWrA6   = (regWrite && hitGrp2Alt)  ? highBufMaskA6 : 8'h00;
  assign lowWrMask  = lowWrA5 | lowWrA7;
  assign highWrMask = highWrA4 | highWrA6;

  // low buffer, cleared by reset or hardware standby
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nextLow_r <= RST_BYTE_ZERO;
    end else if (clearAll) begin
      nextLow_r <= RST_BYTE_ZERO;
    end else begin
      nextLow_r <= mergeBits(nextLow_r, regWrData, lowWrMask);
    end
  end

  // high buffer, cleared by reset or hardware standby
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nextHigh_r <= RST_BYTE_ZERO;
    end else if (clearAll) begin
      nextHigh_r <= RST_BYTE_ZERO;
    end else begin
      nextHigh_r <= mergeBits(nextHigh_r, regWrData, highWrMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables, trigger select, directions
  logic wrLowEn;
  logic wrHighEn;
  logic wrTrig;
  logic wrLowDir;
  logic wrHighDir;

  assign wrLowEn   = regWrite && hitLowEn;
  assign wrHighEn  = regWrite && hitHighEn;
  assign wrTrig    = regWrite && hitTrig;
  assign wrLowDir  = regWrite && hitLowDir;
  assign wrHighDir = regWrite && hitHighDir;

  // control registers, cleared by reset or hardware standby
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lowEnable_r  <= RST_BYTE_ZERO;
      highEnable_r <= RST_BYTE_ZERO;
      trigSel_r    <= RST_TRIG_SEL;
      lowDir_r     <= RST_BYTE_ZERO;
      highDir_r    <= RST_BYTE_ZERO;
    end else if (clearAll) begin
      lowEnable_r  <= RST_BYTE_ZERO;
      highEnable_r <= RST_BYTE_ZERO;
      trigSel_r    <= RST_TRIG_SEL;
      lowDir_r     <= RST_BYTE_ZERO;
      highDir_r    <= RST_BYTE_ZERO;
    end else begin
      if (wrLowEn) lowEnable_r <= regWrData;
      if (wrHighEn) highEnable_r <= regWrData;
      if (wrTrig) trigSel_r <= regWrData;
      if (wrLowDir) lowDir_r <= regWrData;
      if (wrHighDir) highDir_r <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port output data pairs
  pndt_pair_if lowPair ();
  pndt_pair_if highPair ();

  assign lowPair.nextData    = nextLow_r;
  assign lowPair.enableBits  = lowEnable_r;
  assign lowPair.groupFire   = groupFire[1:0];
  assign lowPair.cpuWrData   = regWrData;
  assign lowPair.cpuWrMask   = hitLowOut ? 8'hff : 8'h00;
  assign lowPair.cpuWrite    = regWrite;
  assign highPair.nextData   = nextHigh_r;
  assign highPair.enableBits = highEnable_r;
  assign highPair.groupFire  = groupFire[3:2];
  assign highPair.cpuWrData  = regWrData;
  assign highPair.cpuWrMask  = hitHighOut ? 8'hff : 8'h00;
  assign highPair.cpuWrite   = regWrite;

  pndt_pair_out lowUnit (
    .core_clk (core_clk),
    .rst      (rst),
    .pair     (lowPair)
  );

  pndt_pair_out highUnit (
    .core_clk (core_clk),
    .rst      (rst),
    .pair     (highPair)
  );

  // pin values and directions; software sets direction for pattern pins
  assign patternOut       = {highPair.outData, lowPair.outData};
  assign patternDirection = {highDir_r, lowDir_r};

  ////////////////////////////////////////////////////////////////////////////
  // read path: unused nibbles read as ones, write-only reads ones
  logic [7:0] rdNextLow;
  logic [7:0] rdGrp0Alt;
  logic [7:0] rdNextHigh;
  logic [7:0] rdGrp2Alt;

  // reserved bits forced to ones by the inverse of each address mask
  assign rdNextLow  = (nextLow_r & lowBufMaskA5) | ~lowBufMaskA5;
  assign rdGrp0Alt  = (nextLow_r & lowBufMaskA7) | ~lowBufMaskA7;
  assign rdNextHigh = (nextHigh_r & highBufMaskA4) | ~highBufMaskA4;
  assign rdGrp2Alt  = (nextHigh_r & highBufMaskA6) | ~highBufMaskA6;

  // read selection by address
  always_comb begin
    rdData_nxt = READ_ONES;
    case (regAddr)
      OFF_NEXT_LOW:      rdData_nxt = rdNextLow;
      OFF_NEXT_GRP0_ALT: rdData_nxt = rdGrp0Alt;
      OFF_NEXT_HIGH:     rdData_nxt = rdNextHigh;
      OFF_NEXT_GRP2_ALT: rdData_nxt = rdGrp2Alt;
      OFF_LOW_EN:        rdData_nxt = lowEnable_r;
      OFF_HIGH_EN:       rdData_nxt = highEnable_r;
      OFF_TRIG_SEL:      rdData_nxt = trigSel_r;
      OFF_LOW_OUT:       rdData_nxt = lowPair.outData;
      OFF_HIGH_OUT:      rdData_nxt = highPair.outData;
      default:           rdData_nxt = READ_ONES;
    endcase
  end

  // read data one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= RST_BYTE_ZERO;
    end else begin
      rdData_r <= regRead ? rdData_nxt : RST_BYTE_ZERO;
    end
  end

  assign regRdData = rdData_r;
endmodule : pndt_transfer
`default_nettype wire

// ---- pndt_timer_model.sv ----
// Purpose: timer model issuing compare-match strobes
// Assumes: bench requests are one-cycle pulses
// Notes:   slow adds one cycle of latency
`timescale 1ns/10ps
`default_nettype none
module pndt_timer_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic [3:0] fireReq,
  output var  logic [3:0] compareMatch
);
  logic [3:0] delay_r;
  // one-cycle strobe per channel, prompt or late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      delay_r      <= 4'h0;
      compareMatch <= 4'h0;
    end else begin
      delay_r      <= fireReq;
      compareMatch <= slow ? delay_r : fireReq;
    end
  end
endmodule : pndt_timer_model
`default_nettype wire

// ---- pndt_transfer_chk.sv ----
// Purpose: port checks of the next-data transfer block
// Assumes: one clock domain, async reset
// Notes:   trigger select shadowed to know pair sharing
`timescale 1ns/10ps
`default_nettype none
module pndt_transfer_chk
  import pndt_pkg::*;
#(parameter int NUM_CHANNELS = 4)
(
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    hwStandby,
  input wire logic [15:0]             regAddr,
  input wire logic [7:0]              regWrData,
  input wire logic                    regWrite,
  input wire logic                    regRead,
  input wire logic [7:0]              regRdData,
  input wire logic [NUM_CHANNELS-1:0] compareMatch,
  input wire logic [15:0]             patternOut,
  input wire logic [15:0]             patternDirection
);
  logic [2:0] sbPipe_r;
  logic       sbOn_r;
  // mirror of the standby pin filter: three stages, counts once two agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sbPipe_r <= 3'h0;
      sbOn_r   <= 1'h0;
    end else begin
      sbPipe_r <= {sbPipe_r[1:0], hwStandby};
      if (sbPipe_r[1] == sbPipe_r[2]) sbOn_r <= sbPipe_r[1];
    end
  end
  logic [7:0] trigSel_r;
  // shadow of the trigger select register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) trigSel_r <= RST_TRIG_SEL;
    else if (sbOn_r) trigSel_r <= RST_TRIG_SEL;
    else if (regWrite && regAddr == OFF_TRIG_SEL) trigSel_r <= regWrData;
  end
  wire logic lowSh = trigSel_r[3:2] == trigSel_r[1:0];
  wire logic highSh = trigSel_r[7:6] == trigSel_r[5:4];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rdAt(logic [15:0] a, logic c);
    regRead && regAddr == a && c;
  endsequence
  sequence stbyThenRd;
    hwStandby[*4] ##1 (!hwStandby)[*6] ##1 rdAt(OFF_LOW_EN, 1'b1);
  endsequence
  ////////////////////////////////////////////////////////////
  dir_read_a: assert property (rdAt(OFF_HIGH_DIR, 1'b1) |=> regRdData == READ_ONES)
    else $error("direction read not ones");
  dir_write_a: assert property (regWrite && regAddr == OFF_HIGH_DIR && !sbOn_r
    |=> patternDirection[15:8] == $past(regWrData)) else $error("direction not written");
  grp0_rsv_a: assert property (rdAt(OFF_NEXT_GRP0_ALT, lowSh) |=> regRdData == READ_ONES)
    else $error("shared low alt not ones");
  low_split_a: assert property (rdAt(OFF_NEXT_LOW, !lowSh) |=> regRdData[3:0] == 4'hf)
    else $error("split low nibble not ones");
  grp2_rsv_a: assert property (rdAt(OFF_NEXT_GRP2_ALT, highSh) |=> regRdData == READ_ONES)
    else $error("shared high alt not ones");
  high_split_a: assert property (rdAt(OFF_NEXT_HIGH, !highSh) |=> regRdData[3:0] == 4'hf)
    else $error("split high nibble not ones");
  out_hold_a: assert property (!(|compareMatch) && !regWrite |=> $stable(patternOut))
    else $error("pattern changed without cause");
  stby_clear_a: assert property (stbyThenRd |=> regRdData == RST_BYTE_ZERO)
    else $error("enable not cleared by standby");
endmodule : pndt_transfer_chk
`default_nettype wire

// ---- pndt_transfer_tb.sv ----
// Purpose: self-checking bench of the next-data transfer block
// Assumes: timer model drives the compare strobes
// Notes:   reads queue expectations, a monitor compares
`timescale 1ns/10ps
`default_nettype none
module pndt_transfer_tb;
  import pndt_pkg::*;
  logic core_clk = 0, rst = 1, hwStandby = 0, regWrite = 0, regRead = 0, slow = 0, rdLast = 0;
  logic [15:0] regAddr = 16'h0000, patternOut, patternDirection, expOut, expEn, expNxt;
  logic [7:0] regWrData = 8'h00, regRdData, expTrig = 8'hff;
  logic [3:0] fireReq = 4'h0, compareMatch;
  logic [31:0] r;
  logic [7:0] q[$];
  int errCount = 0, checksDone = 0, cycles = 0;
  always #10 core_clk = ~core_clk;
  pndt_transfer #(.NUM_CHANNELS(4)) u_dut (.core_clk(core_clk), .rst(rst),
    .hwStandby(hwStandby), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .compareMatch(compareMatch),
    .patternOut(patternOut), .patternDirection(patternDirection));
  pndt_timer_model u_tmr (.core_clk(core_clk), .rst(rst), .slow(slow), .fireReq(fireReq),
    .compareMatch(compareMatch));
  ////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : reportAndStop
  // one bus cycle; strobes held until the next call
  task automatic bus(logic w, logic rd, logic [15:0] a, logic [7:0] d, logic [3:0] f);
    regWrite <= w;
    regRead <= rd;
    regAddr <= a;
    regWrData <= d;
    fireReq <= f;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(logic [15:0] a, logic [7:0] d);
    bus(1'b1, 1'b0, a, d, 4'h0);
  endtask : wr
  task automatic rd(logic [15:0] a, logic [7:0] e);
    q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00, 4'h0);
  endtask : rd
  // fire a channel, update the mirror, compare the pins
  task automatic fire(int c);
    bus(1'b0, 1'b0, 16'h0000, 8'h00, 4'(1 << c));
    for (int g = 0; g < 4; g++)
      if (expTrig[2*g+:2] == c[1:0])
        for (int b = 4*g; b < 4*g+4; b++)
          if (expEn[b]) expOut[b] = expNxt[b];
    repeat (slow ? 2 : 1) bus(1'b0, 1'b0, 16'h0000, 8'h00, 4'h0);
    #1 check("pattern", patternOut, expOut);
    @(posedge core_clk);
  endtask : fire
  // read data monitor and hang guard
  always @(posedge core_clk) begin
    if (rdLast) check("read", {8'h00, regRdData}, {8'h00, q.pop_front()});
    rdLast <= regRead;
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      reportAndStop();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(33));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFF_NEXT_LOW, RST_BYTE_ZERO);
    rd(OFF_NEXT_HIGH, RST_BYTE_ZERO);
    rd(OFF_LOW_EN, RST_BYTE_ZERO);
    rd(OFF_TRIG_SEL, RST_TRIG_SEL);
    rd(OFF_NEXT_GRP0_ALT, READ_ONES);
    rd(OFF_NEXT_GRP2_ALT, READ_ONES);
    rd(OFF_HIGH_DIR, READ_ONES);
    rd(16'h0000, READ_ONES);
    wr(OFF_HIGH_DIR, 8'hff);
    wr(OFF_LOW_DIR, 8'hff);
    r = $urandom;
    {expEn, expOut} = r;
    wr(OFF_LOW_OUT, r[7:0]);
    wr(OFF_HIGH_OUT, r[15:8]);
    wr(OFF_LOW_EN, r[23:16]);
    wr(OFF_HIGH_EN, r[31:24]);
    r = $urandom;
    expNxt = r[15:0];
    wr(OFF_NEXT_LOW, r[7:0]);
    wr(OFF_NEXT_HIGH, r[15:8]);
    wr(OFF_HIGH_OUT, r[31:24]);
    expOut[15:8] = (expOut[15:8] & expEn[15:8]) | (r[31:24] & ~expEn[15:8]);
    rd(OFF_HIGH_OUT, expOut[15:8]);
    rd(OFF_LOW_EN, expEn[7:0]);
    check("direction", patternDirection, 16'hffff);
    fire(0);
    fire(3);
    expTrig = 8'he4;
    wr(OFF_TRIG_SEL, expTrig);
    r = $urandom;
    expNxt = {r[23:20], r[27:24], r[7:4], r[11:8]};
    wr(OFF_NEXT_LOW, r[7:0]);
    wr(OFF_NEXT_GRP0_ALT, r[15:8]);
    wr(OFF_NEXT_HIGH, r[23:16]);
    wr(OFF_NEXT_GRP2_ALT, r[31:24]);
    rd(OFF_NEXT_LOW, {r[7:4], 4'hf});
    rd(OFF_NEXT_GRP0_ALT, {4'hf, r[11:8]});
    rd(OFF_NEXT_HIGH, {r[23:20], 4'hf});
    rd(OFF_NEXT_GRP2_ALT, {4'hf, r[27:24]});
    for (int c = 0; c < 4; c++) begin
      slow <= c[1];
      fire(c);
    end
    hwStandby <= 1'b1;
    repeat (4) bus(1'b0, 1'b0, 16'h0000, 8'h00, 4'h0);
    hwStandby <= 1'b0;
    repeat (6) bus(1'b0, 1'b0, 16'h0000, 8'h00, 4'h0);
    rd(OFF_LOW_EN, RST_BYTE_ZERO);
    rd(OFF_NEXT_LOW, RST_BYTE_ZERO);
    rd(OFF_NEXT_HIGH, RST_BYTE_ZERO);
    rd(OFF_TRIG_SEL, RST_TRIG_SEL);
    rd(OFF_LOW_OUT, expOut[7:0]);
    repeat (2) bus(1'b0, 1'b0, 16'h0000, 8'h00, 4'h0);
    reportAndStop();
  end
endmodule : pndt_transfer_tb
bind pndt_transfer pndt_transfer_chk #(.NUM_CHANNELS(NUM_CHANNELS)) u_chk (.core_clk(core_clk),
  .rst(rst), .hwStandby(hwStandby), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .compareMatch(compareMatch), .patternOut(patternOut), .patternDirection(patternDirection));
`default_nettype wire
